// ===== pwd_defines.svh
`ifndef PWD_DEFINES_SVH
`define PWD_DEFINES_SVH

// register addresses on the peripheral transfer port
`define PWD_ADDR_W 7
`define PWD_ADDR_DUTY2 7'h46
`define PWD_ADDR_DUTY1 7'h45
`define PWD_ADDR_DUTY0 7'h44

// duty register layout
`define PWD_DUTY_W 9
`define PWD_DUTY_RST 9'h1FF
`define PWD_LATCH8_MSB 7
`define PWD_DATA_W 16

// shared counter
`define PWD_CNT_W 9
`define PWD_CNT_MASK8 9'h0FF
`define PWD_CNT_MASK9 9'h1FF
`define PWD_SHIFT8 9'h040
`define PWD_SHIFT9 9'h080

// basic clock rates, in hertz, and the master clock rate
`define PWD_MCLK_HZ 40000000
`define PWD_BASE_FAST_HZ 1125000
`define PWD_BASE_SLOW_HZ 112500
`define PWD_ACC_W 26
`define PWD_ACC_MOD 26'(`PWD_MCLK_HZ)
`define PWD_ACC_FAST 26'(`PWD_BASE_FAST_HZ)
`define PWD_ACC_SLOW 26'(`PWD_BASE_SLOW_HZ)
`define PWD_ACC_QUARTER 26'(`PWD_MCLK_HZ / 4)

`endif

// ===== pwd_pkg.sv
`default_nettype none

package pwd_pkg;

  typedef logic [8:0] pwd_duty_t;
  typedef logic [8:0] pwd_count_t;

  typedef enum logic [1:0] {
    PWD_SEL_NONE,
    PWD_SEL_DUTY0,
    PWD_SEL_DUTY1,
    PWD_SEL_DUTY2
  } pwd_reg_sel_e;

endpackage

`default_nettype wire

// ===== pwd_channel.sv
`include "pwd_defines.svh"
`default_nettype none

module pwd_channel #(
  parameter int CH = 0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire pwd_pkg::pwd_duty_t duty,
  input wire pwd_pkg::pwd_count_t count,
  input wire logic wide_mode,
  input wire logic first_quarter,
  input wire logic pwm_sel,
  input wire logic latch_bit,
  input wire logic force_gp,
  output logic pin_o,
  output logic pin_oe_b
);

  // channels 1 and 2 see the counter rotated (channel 0 by zero), so edges do not all coincide
  wire pwd_pkg::pwd_count_t shift_step;
  wire pwd_pkg::pwd_count_t rot_count;
  wire pwd_pkg::pwd_count_t mask;
  wire pwd_pkg::pwd_count_t cmp_count;
  wire pwd_pkg::pwd_duty_t cmp_duty;
  wire wave_high;
  wire gp_mode;
  wire next_level;

  assign shift_step = wide_mode ? `PWD_SHIFT9 : `PWD_SHIFT8;
  assign rot_count = 9'(count + 9'(shift_step * 9'(CH)));
  assign mask = wide_mode ? `PWD_CNT_MASK9 : `PWD_CNT_MASK8;
  assign cmp_count = rot_count & mask;
  assign cmp_duty = duty & mask;

  // equal values still give a quarter basic period of high level
  assign wave_high = (cmp_duty > cmp_count) ||
                     ((cmp_duty == cmp_count) && first_quarter);

  assign gp_mode = force_gp || !pwm_sel;
  assign next_level = gp_mode ? latch_bit : wave_high;

  // open drain: only ever pulls low, the pull-up gives the high level
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pin_o <= 1'b0;
      pin_oe_b <= 1'b0;
    end else begin
      pin_o <= 1'b0;
      pin_oe_b <= next_level;
    end
  end

endmodule

`default_nettype wire

// ===== pwd_pwm_dac.sv
`include "pwd_defines.svh"
`default_nettype none

module pwd_pwm_dac (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [`PWD_ADDR_W-1:0] reg_addr,
  input wire logic reg_put,
  input wire logic reg_get,
  input wire logic [`PWD_DATA_W-1:0] reg_wdata,
  output logic [`PWD_DATA_W-1:0] reg_rdata,
  input wire logic counter_width_select,
  input wire logic base_clock_select,
  input wire logic timer_function_select,
  input wire logic shared_counter_clear,
  input wire logic shared_counter_run,
  input wire logic pin0_output_select,
  input wire logic pin1_output_select,
  input wire logic pin2_output_select,
  input wire logic port_latch_bit0,
  input wire logic port_latch_bit1,
  input wire logic port_latch_bit2,
  input wire logic clock_stop,
  output logic [2:0] wave_out_o,
  output logic [2:0] wave_out_oe_b
);

  pwd_pkg::pwd_duty_t duty_register_channel0;
  pwd_pkg::pwd_duty_t duty_register_channel1;
  pwd_pkg::pwd_duty_t duty_register_channel2;
  pwd_pkg::pwd_count_t shared_count;
  logic [`PWD_ACC_W-1:0] base_acc;

  // ---- basic clock generation ----
  // a fractional accumulator keeps the average rate exact although
  // the master clock is no integer multiple of either basic clock;
  // the cost is a one-cycle jitter on each basic clock edge
  wire [`PWD_ACC_W-1:0] acc_step;
  wire [`PWD_ACC_W:0] acc_sum;
  wire base_tick;
  wire [`PWD_ACC_W-1:0] next_base_acc;
  wire first_quarter;

  assign acc_step = base_clock_select ? `PWD_ACC_SLOW
                                      : `PWD_ACC_FAST;
  assign acc_sum = {1'b0, base_acc} + {1'b0, acc_step};
  assign base_tick = acc_sum >= {1'b0, `PWD_ACC_MOD};
  assign next_base_acc = base_tick
    ? `PWD_ACC_W'(acc_sum - {1'b0, `PWD_ACC_MOD})
    : acc_sum[`PWD_ACC_W-1:0];
  assign first_quarter = base_acc < `PWD_ACC_QUARTER;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      base_acc <= '0;
    end else begin
      base_acc <= next_base_acc;
    end
  end

  // ---- shared counter ----
  // no halt or CE reset input: those states leave it running as is
  wire pwd_pkg::pwd_count_t count_mask;
  wire pwd_pkg::pwd_count_t next_shared_count;

  assign count_mask = counter_width_select ? `PWD_CNT_MASK9
                                           : `PWD_CNT_MASK8;
  assign next_shared_count = 9'(shared_count + 9'h001) &
                             count_mask;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      shared_count <= '0;
    end else if (shared_counter_clear) begin
      shared_count <= '0;
    end else if (shared_counter_run && base_tick) begin
      shared_count <= next_shared_count;
    end
  end

  // ---- register decode ----
  wire pwd_pkg::pwd_reg_sel_e reg_sel;
  wire sel_duty0;
  wire sel_duty1;
  wire sel_duty2;
  wire latch_mode;
  wire pwd_pkg::pwd_duty_t wr_duty9;
  wire pwd_pkg::pwd_duty_t wr_duty8;

  assign reg_sel =
    (reg_addr == `PWD_ADDR_DUTY0) ? pwd_pkg::PWD_SEL_DUTY0 :
    (reg_addr == `PWD_ADDR_DUTY1) ? pwd_pkg::PWD_SEL_DUTY1 :
    (reg_addr == `PWD_ADDR_DUTY2) ? pwd_pkg::PWD_SEL_DUTY2 :
    pwd_pkg::PWD_SEL_NONE;
  assign sel_duty0 = reg_sel == pwd_pkg::PWD_SEL_DUTY0;
  assign sel_duty1 = reg_sel == pwd_pkg::PWD_SEL_DUTY1;
  assign sel_duty2 = reg_sel == pwd_pkg::PWD_SEL_DUTY2;

  // timer use turns channels 1 and 0 into plain byte latches
  assign latch_mode = timer_function_select;
  // only the low nine bits of a transfer are kept
  assign wr_duty9 = reg_wdata[`PWD_DUTY_W-1:0];
  assign wr_duty8 = {1'b0, reg_wdata[`PWD_LATCH8_MSB:0]};

  wire pwd_pkg::pwd_duty_t wr_duty_low;

  assign wr_duty_low = latch_mode ? wr_duty8 : wr_duty9;

  // ---- duty registers ----
  // clock stop reloads all-ones so a restart never begins at zero
  always_ff @(posedge mclk) begin
    if (!rst_b || clock_stop) begin
      duty_register_channel0 <= `PWD_DUTY_RST;
    end else if (reg_put && sel_duty0) begin
      duty_register_channel0 <= wr_duty_low;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || clock_stop) begin
      duty_register_channel1 <= `PWD_DUTY_RST;
    end else if (reg_put && sel_duty1) begin
      duty_register_channel1 <= wr_duty_low;
    end
  end

  // channel 2 is never a byte latch, always nine bits wide
  always_ff @(posedge mclk) begin
    if (!rst_b || clock_stop) begin
      duty_register_channel2 <= `PWD_DUTY_RST;
    end else if (reg_put && sel_duty2) begin
      duty_register_channel2 <= wr_duty9;
    end
  end

  // ---- read path ----
  wire [`PWD_DATA_W-1:0] rd_duty0;
  wire [`PWD_DATA_W-1:0] rd_duty1;
  wire [`PWD_DATA_W-1:0] rd_duty2;
  wire [`PWD_DATA_W-1:0] next_reg_rdata;

  // upper bits of every duty register read as zero
  assign rd_duty0 = {7'h00, duty_register_channel0};
  assign rd_duty1 = {7'h00, duty_register_channel1};
  assign rd_duty2 = {7'h00, duty_register_channel2};
  assign next_reg_rdata = sel_duty0 ? rd_duty0 :
                          sel_duty1 ? rd_duty1 :
                          sel_duty2 ? rd_duty2 :
                          16'h0000;

  // read data stands until the next read strobe
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_get) begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ---- pin control ----
  // timer use and clock stop both force port mode on every pin
  wire force_gp;

  assign force_gp = timer_function_select || clock_stop;

  wire wide_mode;

  assign wide_mode = counter_width_select;

  // one channel instance per pin, all fed from one counter and clock
  pwd_channel #(
    .CH(0)
  ) u_ch0 (
    .mclk(mclk),
    .rst_b(rst_b),
    .duty(duty_register_channel0),
    .count(shared_count),
    .wide_mode(wide_mode),
    .first_quarter(first_quarter),
    .pwm_sel(pin0_output_select),
    .latch_bit(port_latch_bit0),
    .force_gp(force_gp),
    .pin_o(wave_out_o[0]),
    .pin_oe_b(wave_out_oe_b[0])
  );

  pwd_channel #(
    .CH(1)
  ) u_ch1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .duty(duty_register_channel1),
    .count(shared_count),
    .wide_mode(wide_mode),
    .first_quarter(first_quarter),
    .pwm_sel(pin1_output_select),
    .latch_bit(port_latch_bit1),
    .force_gp(force_gp),
    .pin_o(wave_out_o[1]),
    .pin_oe_b(wave_out_oe_b[1])
  );

  pwd_channel #(
    .CH(2)
  ) u_ch2 (
    .mclk(mclk),
    .rst_b(rst_b),
    .duty(duty_register_channel2),
    .count(shared_count),
    .wide_mode(wide_mode),
    .first_quarter(first_quarter),
    .pwm_sel(pin2_output_select),
    .latch_bit(port_latch_bit2),
    .force_gp(force_gp),
    .pin_o(wave_out_o[2]),
    .pin_oe_b(wave_out_oe_b[2])
  );

endmodule

`default_nettype wire

// ===== pwd_pwm_dac_properties.sv
`default_nettype none
module pwd_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [6:0] reg_addr,
  input wire logic reg_get,
  input wire logic [15:0] reg_rdata,
  input wire logic timer_function_select,
  input wire logic clock_stop,
  input wire logic pin0_output_select,
  input wire logic port_latch_bit0,
  input wire logic port_latch_bit1,
  input wire logic port_latch_bit2,
  input wire logic [2:0] wave_out_o,
  input wire logic [2:0] wave_out_oe_b
);
  wire logic [2:0] latch3 =
    {port_latch_bit2, port_latch_bit1, port_latch_bit0};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence stop_read;
    clock_stop ##1 (clock_stop && reg_get && reg_addr == 7'h46);
  endsequence
  chk_out_low: assert property (wave_out_o == 3'h0)
    else $error("pin value driven high");
  chk_reset_pins: assert property (
    $rose(rst_b) |-> wave_out_oe_b == 3'h0)
    else $error("pins not low after reset");
  chk_timer_latch: assert property (
    timer_function_select |=> wave_out_oe_b == $past(latch3))
    else $error("timer use did not show latches");
  chk_stop_latch: assert property (
    clock_stop |=> wave_out_oe_b == $past(latch3))
    else $error("clock stop did not show latches");
  chk_pin0_port: assert property (
    !pin0_output_select |=> wave_out_oe_b[0] == $past(port_latch_bit0))
    else $error("pin0 port mode wrong");
  chk_rdata_upper: assert property (reg_rdata[15:9] == 7'h00)
    else $error("upper read bits not zero");
  chk_rdata_holds: assert property (!reg_get |=> $stable(reg_rdata))
    else $error("read data moved without read");
  chk_stop_reload: assert property (
    stop_read |=> reg_rdata == 16'h01FF)
    else $error("duty not reloaded in clock stop");
endmodule
bind pwd_pwm_dac pwd_chk chk_u (.mclk, .rst_b, .reg_addr, .reg_get,
  .reg_rdata, .timer_function_select, .clock_stop, .pin0_output_select,
  .port_latch_bit0, .port_latch_bit1, .port_latch_bit2, .wave_out_o,
  .wave_out_oe_b);
`default_nettype wire

// ===== pwd_filter_model.sv
`default_nettype none
module pwd_filter_model (
  input wire logic mclk,
  input wire logic restart,
  input wire logic [2:0] pin_o,
  input wire logic [2:0] pin_oe_b,
  output logic [2:0] level,
  output int high_cyc [3]
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pin rises through the pull-up
  assign level = pin_oe_b | pin_o;
  // integrator stands in for the low-pass filter
  always @(posedge mclk)
    for (int i = 0; i < 3; i++)
      high_cyc[i] <= restart ? 0 : high_cyc[i] + int'(level[i]);
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_b = 0, reg_put = 0, reg_get = 0;
  logic [6:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic wide = 0, slow = 0, tmr = 0, clr = 1, run = 0, stop = 0, restart = 1;
  logic [2:0] sel = 0, lat = 0, wave_out_o, wave_out_oe_b, level;
  int errors = 0, total_checks = 0, cyc = 0, e, high_cyc [3];
  int d [3] = '{0, 128, 255};
  always #12.5 mclk = ~mclk;
  pwd_pwm_dac dut_u (
    .mclk, .rst_b, .reg_addr, .reg_put, .reg_get, .reg_wdata, .reg_rdata,
    .counter_width_select(wide), .base_clock_select(slow),
    .timer_function_select(tmr), .shared_counter_clear(clr),
    .shared_counter_run(run), .pin0_output_select(sel[0]),
    .pin1_output_select(sel[1]), .pin2_output_select(sel[2]),
    .port_latch_bit0(lat[0]), .port_latch_bit1(lat[1]),
    .port_latch_bit2(lat[2]), .clock_stop(stop), .wave_out_o, .wave_out_oe_b
  );
  pwd_filter_model filt_u (.mclk, .restart, .pin_o(wave_out_o),
    .pin_oe_b(wave_out_oe_b), .level, .high_cyc);
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
  end
  task automatic put(input logic [6:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_put <= 1'b1;
    @(posedge mclk);
    reg_put <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic get(input logic [6:0] a, input logic [15:0] x);
    reg_addr <= a;
    reg_get <= 1'b1;
    @(posedge mclk);
    reg_get <= 1'b0;
    @(posedge mclk);
    `CHK(reg_rdata, x)
  endtask
  task automatic pins(input logic [2:0] x);
    repeat (3) @(posedge mclk);
    `CHK(level, x)
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    `CHK(level, 3'h0)
    rst_b <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 3; i++)
      get(7'(68 + i), 16'h01FF);
    get(7'h47, 16'h0000);
    put(7'h46, 16'hFE5A);
    get(7'h46, 16'h005A);
    lat <= 3'h5;
    pins(3'h5);
    tmr <= 1'b1;
    sel <= 3'h7;
    put(7'h44, 16'h01AB);
    get(7'h44, 16'h00AB);
    pins(3'h5);
    tmr <= 1'b0;
    // counter held at zero, so only the channel offsets differ
    put(7'h46, 16'h0141);
    put(7'h45, 16'h0041);
    put(7'h44, 16'h0041);
    pins(3'h3);
    wide <= 1'b1;
    pins(3'h5);
    for (int i = 0; i < 3; i++)
      put(7'(68 + i), 16'(d[i]));
    for (int w = 0; w < 2; w++) begin
      wide <= w[0];
      clr <= 1'b0;
      run <= 1'b1;
      restart <= 1'b0;
      // one full period, so the start phase cancels out
      repeat (9102 << w) @(posedge mclk);
      for (int i = 0; i < 3; i++) begin
        e = (4 * d[i] + 1) * 80 / 9;
        `CHK(high_cyc[i] > e - 40 && high_cyc[i] < e + 40, 1'b1)
      end
      // duty zero still shows about a quarter count of high level
      `CHK(high_cyc[0] > 3 && high_cyc[0] < 16, 1'b1)
      restart <= 1'b1;
      @(posedge mclk);
    end
    // short duty: only the fast rate ends the high phase in the window
    put(7'h44, 16'h0008);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      clr <= 1'b1;
      restart <= 1'b1;
      repeat (2) @(posedge mclk);
      clr <= 1'b0;
      restart <= 1'b0;
      repeat (1000) @(posedge mclk);
      e = s ? 990 : 240;
      `CHK(high_cyc[0] > e && high_cyc[0] < e + 70, 1'b1)
    end
    stop <= 1'b1;
    pins(3'h5);
    get(7'h45, 16'h01FF);
    get(7'h46, 16'h01FF);
    summarize();
  end
endmodule
`default_nettype wire
